/* core/flic_core.sv */
// Local design decisions: the register offsets and the address-and-strobe port.
module flic_core (
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire logic [7:0]                 reg_addr,
    input  wire logic [7:0]                 reg_wdata,
    input  wire logic                       reg_we,
    input  wire logic                       reg_re,
    output logic      [7:0]                 reg_rdata,
    input  wire logic                       cycle_tick,
    input  wire logic                       last_cycle,
    input  wire logic                       return_from_interrupt_instr_exec,
    input  wire logic [flic_pkg::NEXT-1:0]  ext_request_pin,
    input  wire logic [flic_pkg::NPER-1:0]  periph_flag,
    output logic      [flic_pkg::NPER-1:0]  periph_ack,
    output logic                            hw_long_call,
    output logic      [15:0]                irq_vector,
    output logic      [3:0]                 irq_source,
    output logic      [flic_pkg::NLVL-1:0]  in_progress
);
    logic                       rst_s1_r;
    logic                       rst_n_r;
    logic [7:0]                 ie_r;
    logic [7:0]                 ip_r;
    logic [7:0]                 iph_r;
    logic [7:0]                 aux_irq_enable_reg_r;
    logic [7:0]                 auxip_r;
    logic [7:0]                 auxiph_r;
    logic [7:0]                 ext_irq_ctrl_reg_r;
    logic [flic_pkg::NEXT-1:0]  ext_type_r;
    logic [flic_pkg::NEXT-1:0]  ext_flag_r;
    logic [flic_pkg::NEXT-1:0]  pin_s_r;
    logic [flic_pkg::NSRC-1:0]  samp_r;
    logic [flic_pkg::NLVL-1:0]  in_prog_r;
    logic                       wr_seen_r;
    logic                       call_r;
    logic [15:0]                vec_r;
    logic [3:0]                 src_r;
    logic [1:0]                 call_lvl_r;
    logic [flic_pkg::NPER-1:0]  ack_r;
    logic [7:0]                 rdata_r;
    logic [7:0]                 rd_val;
    logic [7:0]                 ext_irq_ctrl_reg_ext;
    logic [7:0]                 timer_ctrl_reg_ext;
    wire [flic_pkg::NSRC-1:0]   flag_vec;
    wire [flic_pkg::NSRC-1:0]   en_vec;
    wire [flic_pkg::NSRC-1:0]   lo_vec;
    wire [flic_pkg::NSRC-1:0]   hi_vec;
    wire [flic_pkg::NSRC-1:0]   pend;
    wire [flic_pkg::NSRC-1:0]   better;
    wire [flic_pkg::NSRC-1:0]   hw_clr_vec;
    wire                        win_found;
    wire [1:0]                  win_lvl;
    wire [3:0]                  win_idx;
    wire                        allowed;
    wire                        blocked;
    wire                        go;
    wire [1:0]                  top;
    wire [flic_pkg::NLVL-1:0]   in_prog_nxt;
    wire [15:0]                 vec_nxt;
    // highest-level pending source; lowest index wins a tie
    function automatic logic [6:0] pick_src(
        input logic [flic_pkg::NSRC-1:0] p,
        input logic [flic_pkg::NSRC-1:0] hi,
        input logic [flic_pkg::NSRC-1:0] lo
    );
        logic       f;
        logic [1:0] bl;
        logic [3:0] bi;
        f  = 1'b0;
        bl = 2'b00;
        bi = 4'h0;
        for (int i = flic_pkg::NSRC - 1; i >= 0; i--)
        begin
            if (p[i] && (!f || {hi[i], lo[i]} >= bl))
            begin
                f  = 1'b1;
                bl = {hi[i], lo[i]};
                bi = 4'(i);
            end
        end
        return {f, bl, bi};
    endfunction
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            {rst_n_r, rst_s1_r} <= 2'b00;
        else
            {rst_n_r, rst_s1_r} <= {rst_s1_r, 1'b1};
    end
    assign en_vec = {aux_irq_enable_reg_r[flic_pkg::LO_W-1:0], ext_irq_ctrl_reg_r[flic_pkg::XI_EX3],
                     ext_irq_ctrl_reg_r[flic_pkg::XI_EX2], ie_r[flic_pkg::LO_W-1:0]};
    assign lo_vec = {auxip_r[flic_pkg::LO_W-1:0], ext_irq_ctrl_reg_r[flic_pkg::XI_PX3],
                     ext_irq_ctrl_reg_r[flic_pkg::XI_PX2], ip_r[flic_pkg::LO_W-1:0]};
    assign hi_vec = {auxiph_r[flic_pkg::LO_W-1:0], iph_r};
    // enables apply at the poll, so a late disable still wins
    assign pend = samp_r & en_vec &
                  {flic_pkg::NSRC{ie_r[flic_pkg::EA_BIT]}};
    assign {win_found, win_lvl, win_idx}
        = pick_src(pend, hi_vec, lo_vec);
    assign top       = in_prog_r[3] ? 2'h3 : in_prog_r[2] ? 2'h2
                     : in_prog_r[1] ? 2'h1 : 2'h0;
    assign allowed   = !(|in_prog_r) || (win_lvl > top);
    assign blocked   = return_from_interrupt_instr_exec || wr_seen_r || reg_we;
    assign go = cycle_tick && last_cycle && win_found
             && allowed && !blocked;
    assign vec_nxt = flic_pkg::VEC_BASE
                   + (16'(win_idx) << flic_pkg::VEC_SHIFT);
    // return clears only the top level; a plain return never gets here
    assign in_prog_nxt = (in_prog_r
        & ~(return_from_interrupt_instr_exec ? (4'h1 << top) : 4'h0))
        | (go ? (4'h1 << win_lvl) : 4'h0);
    genvar gx;
    generate
        for (gx = 0; gx < flic_pkg::NPER; gx++)
        begin : g_per
            assign flag_vec[flic_pkg::PER_SRC[gx]]   = periph_flag[gx];
            assign hw_clr_vec[flic_pkg::PER_SRC[gx]] = 1'b0;
        end
        for (gx = 0; gx < flic_pkg::NEXT; gx++)
        begin : g_ext
            localparam int S = flic_pkg::EXT_SRC[gx];
            wire hit   = reg_we && reg_addr == flic_pkg::EXT_ADDR[gx];
            wire fall  = cycle_tick && pin_s_r[gx]
                      && !ext_request_pin[gx];
            wire hwclr = go && win_idx == 4'(S)
                      && ext_type_r[gx];
            wire swclr = hit && !reg_wdata[flic_pkg::EXT_IE_BIT[gx]];
            wire swset = hit && reg_wdata[flic_pkg::EXT_IE_BIT[gx]];
            wire typ   = hit ? reg_wdata[flic_pkg::EXT_IT_BIT[gx]]
                             : ext_type_r[gx];
            assign flag_vec[S]   = ext_flag_r[gx];
            assign hw_clr_vec[S] = hwclr;
            always_ff @(posedge clk or negedge rst_n_r)
            begin
                if (!rst_n_r)
                begin
                    ext_type_r[gx] <= 1'b0;
                    ext_flag_r[gx] <= 1'b0;
                    pin_s_r[gx]    <= 1'b1;
                end
                else
                begin
                    ext_type_r[gx] <= typ;
                    pin_s_r[gx]    <= cycle_tick ? ext_request_pin[gx]
                                                 : pin_s_r[gx];
                    // edge: a new edge beats any clear; level: follows pin
                    ext_flag_r[gx] <= typ ? (fall || swset
                        || (ext_flag_r[gx] && !hwclr && !swclr))
                        : !ext_request_pin[gx];
                end
            end
        end
        for (gx = 0; gx < flic_pkg::NSRC; gx++)
        begin : g_better
            assign better[gx] = pend[gx]
                && ({hi_vec[gx], lo_vec[gx]} > win_lvl
                 || ({hi_vec[gx], lo_vec[gx]} == win_lvl
                  && 4'(gx) < win_idx));
        end
    endgenerate
    always_comb
    begin
        ext_irq_ctrl_reg_ext = 8'h00;
        timer_ctrl_reg_ext  = 8'h00;
        for (int x = 0; x < flic_pkg::NEXT; x++)
        begin
            if (flic_pkg::EXT_ADDR[x] == flic_pkg::ADDR_EXT_IRQ_CTRL_REG)
            begin
                ext_irq_ctrl_reg_ext[flic_pkg::EXT_IE_BIT[x]] = ext_flag_r[x];
                ext_irq_ctrl_reg_ext[flic_pkg::EXT_IT_BIT[x]] = ext_type_r[x];
            end
            else
            begin
                timer_ctrl_reg_ext[flic_pkg::EXT_IE_BIT[x]] = ext_flag_r[x];
                timer_ctrl_reg_ext[flic_pkg::EXT_IT_BIT[x]] = ext_type_r[x];
            end
        end
    end
    always_comb
    begin
        if (reg_addr == flic_pkg::ADDR_IE)
            rd_val = ie_r;
        else if (reg_addr == flic_pkg::ADDR_IP)
            rd_val = ip_r;
        else if (reg_addr == flic_pkg::ADDR_IPH)
            rd_val = iph_r;
        else if (reg_addr == flic_pkg::ADDR_AUX_IRQ_ENABLE_REG)
            rd_val = aux_irq_enable_reg_r;
        else if (reg_addr == flic_pkg::ADDR_AUXIP)
            rd_val = auxip_r;
        else if (reg_addr == flic_pkg::ADDR_AUXIPH)
            rd_val = auxiph_r;
        else if (reg_addr == flic_pkg::ADDR_EXT_IRQ_CTRL_REG)
            rd_val = ext_irq_ctrl_reg_r | ext_irq_ctrl_reg_ext;
        else if (reg_addr == flic_pkg::ADDR_TIMER_CTRL_REG)
            rd_val = timer_ctrl_reg_ext;
        else
            rd_val = 8'h00;
    end
    always_ff @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            ie_r     <= flic_pkg::RST_BYTE;
            ip_r     <= flic_pkg::RST_BYTE;
            iph_r    <= flic_pkg::RST_BYTE;
            aux_irq_enable_reg_r  <= flic_pkg::RST_BYTE;
            auxip_r  <= flic_pkg::RST_BYTE;
            auxiph_r <= flic_pkg::RST_BYTE;
            ext_irq_ctrl_reg_r  <= flic_pkg::RST_BYTE;
        end
        else if (reg_we)
        begin
            if (reg_addr == flic_pkg::ADDR_IE)
                ie_r <= reg_wdata & flic_pkg::IE_MASK;
            else if (reg_addr == flic_pkg::ADDR_IP)
                ip_r <= reg_wdata & flic_pkg::AUX_MASK;
            else if (reg_addr == flic_pkg::ADDR_IPH)
                iph_r <= reg_wdata;
            else if (reg_addr == flic_pkg::ADDR_AUX_IRQ_ENABLE_REG)
                aux_irq_enable_reg_r <= reg_wdata & flic_pkg::AUX_MASK;
            else if (reg_addr == flic_pkg::ADDR_AUXIP)
                auxip_r <= reg_wdata & flic_pkg::AUX_MASK;
            else if (reg_addr == flic_pkg::ADDR_AUXIPH)
                auxiph_r <= reg_wdata & flic_pkg::AUX_MASK;
            else if (reg_addr == flic_pkg::ADDR_EXT_IRQ_CTRL_REG)
                ext_irq_ctrl_reg_r <= reg_wdata & flic_pkg::XI_CFG_MASK;
        end
    end
    always_ff @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            samp_r     <= '0;
            in_prog_r  <= '0;
            wr_seen_r  <= 1'b0;
            call_r     <= 1'b0;
            vec_r      <= 16'h0000;
            src_r      <= 4'h0;
            call_lvl_r <= 2'b00;
            ack_r      <= '0;
            rdata_r    <= 8'h00;
        end
        else
        begin
            // overwritten every cycle: nothing blocked is remembered
            samp_r    <= cycle_tick ? (flag_vec & ~hw_clr_vec)
                                    : samp_r;
            in_prog_r <= in_prog_nxt;
            // write blocks until its instruction ends; the write wins
            wr_seen_r <= reg_we
                || (wr_seen_r && !(cycle_tick && last_cycle));
            call_r    <= go;
            vec_r     <= go ? vec_nxt : vec_r;
            src_r     <= go ? win_idx : src_r;
            call_lvl_r <= go ? win_lvl : call_lvl_r;
            // only the plain timers get an acknowledge to clear on
            for (int p = 0; p < flic_pkg::NPER; p++)
                ack_r[p] <= go && flic_pkg::PER_HW_CLR[p]
                    && win_idx == 4'(flic_pkg::PER_SRC[p]);
            rdata_r   <= reg_re ? rd_val : 8'h00;
        end
    end

    assign reg_rdata    = rdata_r;
    assign hw_long_call = call_r;
    assign irq_vector   = vec_r;
    assign irq_source   = src_r;
    assign in_progress  = in_prog_r;
    assign periph_ack   = ack_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_r);

    a_global_off: assert property (
        cycle_tick && !ie_r[flic_pkg::EA_BIT] |=> !call_r)
        else $error("vector with global enable low");
    a_src_enable: assert property (
        go |-> en_vec[win_idx] && samp_r[win_idx])
        else $error("vector for a disabled source");
    a_level_code: assert property (
        go |=> call_lvl_r == {$past(hi_vec[win_idx]),
                              $past(lo_vec[win_idx])})
        else $error("wrong level taken");
    a_preempt_only: assert property (
        call_r && $past(|in_prog_r) |-> call_lvl_r > $past(top))
        else $error("preempted by equal or lower level");
    a_best_wins: assert property (go |-> better == '0)
        else $error("a better pending source was passed over");
    a_last_cycle: assert property (
        call_r |-> $past(cycle_tick && last_cycle))
        else $error("vector outside final cycle");
    a_write_block: assert property (reg_we |=> !call_r)
        else $error("vector during register write");
    a_vec_spacing: assert property (
        call_r |-> irq_vector == flic_pkg::VEC_BASE
            + (16'(src_r) << flic_pkg::VEC_SHIFT))
        else $error("vector address spacing wrong");
    a_return_from_interrupt_instr_clear: assert property (
        return_from_interrupt_instr_exec && |in_prog_r |=> !in_prog_r[$past(top)]
            && $countones(in_prog_r) < $countones($past(in_prog_r)))
        else $error("return did not end top routine");
    a_prog_set: assert property (
        go |=> in_prog_r[call_lvl_r])
        else $error("in-progress bit not set");

    c_preempt: cover property (go && |in_prog_r);
    c_tie: cover property (go && $countones(pend) > 1);
    c_edge_vec: cover property (go && |hw_clr_vec);
    c_nested_ret: cover property (return_from_interrupt_instr_exec && $countones(in_prog_r) > 1);
endmodule // flic_core

/* pkg/flic_pkg.sv */
package flic_pkg;
    localparam int NSRC = 14;
    localparam int NEXT = 4;
    localparam int NPER = 10;
    localparam int NLVL = 4;

    localparam logic [7:0] ADDR_IE     = 8'ha8;
    localparam logic [7:0] ADDR_IP     = 8'hb8;
    localparam logic [7:0] ADDR_IPH    = 8'hb7;
    localparam logic [7:0] ADDR_AUX_IRQ_ENABLE_REG  = 8'had;
    localparam logic [7:0] ADDR_AUXIP  = 8'hae;
    localparam logic [7:0] ADDR_AUXIPH = 8'haf;
    localparam logic [7:0] ADDR_EXT_IRQ_CTRL_REG  = 8'hc0;
    localparam logic [7:0] ADDR_TIMER_CTRL_REG   = 8'h88;

    localparam logic [7:0] RST_BYTE    = 8'h00;
    localparam logic [7:0] IE_MASK     = 8'hbf;
    localparam logic [7:0] AUX_MASK    = 8'h3f;
    localparam logic [7:0] XI_CFG_MASK = 8'hcc;
    localparam int         EA_BIT      = 7;
    localparam int         XI_PX2      = 3;
    localparam int         XI_EX2      = 2;
    localparam int         XI_PX3      = 7;
    localparam int         XI_EX3      = 6;
    localparam int         LO_W        = 6;

    // per external input: register, flag bit, type bit, source index
    localparam logic [7:0] EXT_ADDR [NEXT] =
        '{ADDR_TIMER_CTRL_REG, ADDR_TIMER_CTRL_REG, ADDR_EXT_IRQ_CTRL_REG, ADDR_EXT_IRQ_CTRL_REG};
    localparam int EXT_IE_BIT [NEXT] = '{1, 3, 1, 5};
    localparam int EXT_IT_BIT [NEXT] = '{0, 2, 0, 4};
    localparam int EXT_SRC    [NEXT] = '{0, 2, 6, 7};
    // on-chip sources in polling order
    localparam int PER_SRC    [NPER] = '{1, 3, 4, 5, 8, 9, 10, 11, 12, 13};
    // on-chip flags that the vectoring may clear (both plain timers)
    localparam logic [NPER-1:0] PER_HW_CLR = 10'h003;

    localparam logic [15:0] VEC_BASE  = 16'h0003;
    localparam int          VEC_SHIFT = 3;
endpackage

/* tb/flic_core_model.sv */
module flic_core_model (
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire logic                       end_ok,
    input  wire logic                       return_from_interrupt_instr_req,
    input  wire logic [flic_pkg::NPER-1:0]  flag_set,
    input  wire logic [flic_pkg::NPER-1:0]  flag_clr,
    input  wire logic [flic_pkg::NPER-1:0]  periph_ack,
    output logic                            cycle_tick,
    output logic                            last_cycle,
    output logic                            return_from_interrupt_instr_exec,
    output logic      [flic_pkg::NPER-1:0]  periph_flag
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] div_r;
    logic       return_from_interrupt_instr_r;
    // one instruction cycle every four clocks
    assign cycle_tick = (div_r == 2'h3);
    assign last_cycle = end_ok;
    assign return_from_interrupt_instr_exec  = cycle_tick & return_from_interrupt_instr_r;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div_r       <= 2'h0;
            return_from_interrupt_instr_r      <= 1'b0;
            periph_flag <= '0;
        end
        else
        begin
            div_r       <= div_r + 2'h1;
            return_from_interrupt_instr_r      <= return_from_interrupt_instr_req | (return_from_interrupt_instr_r & ~cycle_tick);
            // only the timer owners take the acknowledge as a clear
            periph_flag <= flag_set | (periph_flag & ~flag_clr
                           & ~(periph_ack & flic_pkg::PER_HW_CLR));
        end
    end
endmodule // flic_core_model

/* tb/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_we = 1'b0;
    logic        reg_re = 1'b0;
    logic [7:0]  reg_rdata;
    logic        cycle_tick;
    logic        last_cycle;
    logic        return_from_interrupt_instr_exec;
    logic [3:0]  ext_request_pin = 4'hf;
    logic [9:0]  periph_flag;
    logic [9:0]  periph_ack;
    logic        hw_long_call;
    logic [15:0] irq_vector;
    logic [3:0]  irq_source;
    logic [3:0]  in_progress;
    logic        end_ok = 1'b1;
    logic        return_from_interrupt_instr_req = 1'b0;
    logic [9:0]  flag_set = '0;
    logic [9:0]  flag_clr = '0;
    logic        gate_r = 1'b0;
    logic [31:0] seed = 32'h0e76;
    int          bad_count = 0;
    int          n_checks = 0;
    localparam logic [7:0] RA [9] = '{flic_pkg::ADDR_IE, flic_pkg::ADDR_IP,
        flic_pkg::ADDR_IPH, flic_pkg::ADDR_AUX_IRQ_ENABLE_REG, flic_pkg::ADDR_AUXIP,
        flic_pkg::ADDR_AUXIPH, flic_pkg::ADDR_EXT_IRQ_CTRL_REG, flic_pkg::ADDR_TIMER_CTRL_REG,
        8'h00};
    localparam logic [7:0] RM [9] = '{8'hbf, 8'h3f, 8'hff, 8'h3f, 8'h3f,
        8'h3f, 8'hff, 8'h0f, 8'h00};

    always #2.5 clk = ~clk;

    flic_core uut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata), .cycle_tick(cycle_tick),
        .last_cycle(last_cycle), .return_from_interrupt_instr_exec(return_from_interrupt_instr_exec),
        .ext_request_pin(ext_request_pin), .periph_flag(periph_flag),
        .periph_ack(periph_ack), .hw_long_call(hw_long_call),
        .irq_vector(irq_vector), .irq_source(irq_source),
        .in_progress(in_progress));
    flic_core_model u_core (.clk(clk), .rst_b(rst_b), .end_ok(end_ok),
        .return_from_interrupt_instr_req(return_from_interrupt_instr_req), .flag_set(flag_set), .flag_clr(flag_clr),
        .periph_ack(periph_ack), .cycle_tick(cycle_tick),
        .last_cycle(last_cycle), .return_from_interrupt_instr_exec(return_from_interrupt_instr_exec),
        .periph_flag(periph_flag));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // only vectoring to the two plain timers may clear an on-chip flag
    function automatic logic [15:0] ack_exp(input int src);
        ack_exp = 16'h0000;
        for (int i = 0; i < flic_pkg::NPER; i++)
            if (flic_pkg::PER_SRC[i] == src && flic_pkg::PER_HW_CLR[i])
                ack_exp[i] = 1'b1;
    endfunction

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_we    <= 1'b1;
        @(posedge clk);
        reg_we    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_re   <= 1'b1;
        @(posedge clk);
        reg_re   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic cfg(input logic [13:0] en, input logic [27:0] lv,
                       input logic ea);
        logic [7:0] ip = 8'h00;
        logic [7:0] iph = 8'h00;
        logic [7:0] ae = 8'h00;
        logic [7:0] al = 8'h00;
        logic [7:0] ah = 8'h00;
        for (int i = 0; i < 6; i++)
        begin
            ip[i]  = lv[2*i];
            iph[i] = lv[2*i+1];
            ae[i]  = en[8+i];
            al[i]  = lv[16+2*i];
            ah[i]  = lv[17+2*i];
        end
        iph[6] = lv[13];
        iph[7] = lv[15];
        wr(flic_pkg::ADDR_IP, ip);
        wr(flic_pkg::ADDR_IPH, iph);
        wr(flic_pkg::ADDR_AUX_IRQ_ENABLE_REG, ae);
        wr(flic_pkg::ADDR_AUXIP, al);
        wr(flic_pkg::ADDR_AUXIPH, ah);
        wr(flic_pkg::ADDR_EXT_IRQ_CTRL_REG, {lv[14], en[7], 2'b00, lv[12], en[6], 2'b00});
        wr(flic_pkg::ADDR_IE, {ea, 1'b0, en[5:0]});
    endtask

    // level requests: pins held low until released, as the far side must
    task automatic raise(input logic [13:0] r);
        @(posedge clk);
        for (int k = 0; k < 4; k++)
            ext_request_pin[k] <= ~r[flic_pkg::EXT_SRC[k]];
        for (int i = 0; i < 10; i++)
            flag_set[i] <= r[flic_pkg::PER_SRC[i]];
        @(posedge clk);
        flag_set <= '0;
    endtask

    task automatic drop();
        raise(14'h0000);
        flag_clr <= '1;
        @(posedge clk);
        flag_clr <= '0;
        repeat (12) @(posedge clk);
    endtask

    task automatic wait_call(input int lim, output bit got);
        got = 1'b0;
        for (int i = 0; i < lim && !got; i++)
        begin
            @(posedge clk);
            #1;
            got = (hw_long_call === 1'b1);
        end
    endtask

    task automatic expect_call(input int src, input logic [3:0] ipx);
        bit got;
        wait_call(200, got);
        if (!got)
        begin
            bad_count++;
            print_verdict();
        end
        else
        begin
            check("source", 16'(irq_source), 16'(src));
            check("vector", irq_vector,
                  flic_pkg::VEC_BASE + 16'(src * 8));
            check("in progress", 16'(in_progress), 16'(ipx));
            check("ack pulse", 16'(periph_ack), ack_exp(src));
        end
    endtask

    task automatic expect_none(input int lim);
        bit got;
        wait_call(lim, got);
        check("no call", 16'(got), 16'h0);
    endtask

    task automatic do_return_from_interrupt_instr();
        @(posedge clk);
        return_from_interrupt_instr_req <= 1'b1;
        @(posedge clk);
        return_from_interrupt_instr_req <= 1'b0;
        #1;
        for (int i = 0; i < 20 && return_from_interrupt_instr_exec !== 1'b1; i++)
            @(posedge clk) #1;
        if (return_from_interrupt_instr_exec !== 1'b1)
        begin
            bad_count++;
            print_verdict();
        end
        else
            @(posedge clk) #1;
    endtask

    task automatic round(input logic [13:0] en, input logic [27:0] lv,
                         input logic [13:0] r);
        int w = -1;
        int best = -1;
        for (int s = 0; s < 14; s++)
            if (r[s] && en[s] && int'(lv[2*s+:2]) > best)
            begin
                best = int'(lv[2*s+:2]);
                w = s;
            end
        cfg(en, lv, 1'b1);
        raise(r);
        if (w < 0)
            expect_none(40);
        else
            expect_call(w, 4'(1 << best));
        drop();
        if (w >= 0)
            do_return_from_interrupt_instr();
        check("idle", 16'(in_progress), 16'h0);
    endtask

    always @(posedge clk)
    begin
        gate_r <= cycle_tick & last_cycle & ~return_from_interrupt_instr_exec & ~reg_we;
        if (hw_long_call === 1'b1)
            check("call gate", 16'(gate_r), 16'h1);
        if (periph_ack !== '0)
            check("ack", 16'(periph_ack & ~flic_pkg::PER_HW_CLR), 16'h0);
    end

    initial
    begin
        logic [7:0]  d;
        logic [27:0] lv;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 9; i++)
        begin
            rd(RA[i], d);
            check("reset value", 16'(d), 16'(flic_pkg::RST_BYTE));
            wr(RA[i], 8'hff);
            rd(RA[i], d);
            check("readback", 16'(d), 16'(RM[i]));
            wr(RA[i], 8'h00);
        end
        cfg('1, '0, 1'b0);
        raise(14'h0001);
        expect_none(40);
        drop();
        cfg('1, '0, 1'b1);
        expect_none(40);
        end_ok <= 1'b0;
        raise(14'h0001);
        expect_none(40);
        end_ok <= 1'b1;
        expect_call(0, 4'h1);
        drop();
        do_return_from_interrupt_instr();
        lv = '0;
        lv[3:2] = 2'h1;
        lv[7:6] = 2'h1;
        lv[5:4] = 2'h3;
        cfg('1, lv, 1'b1);
        raise(14'h0002);
        expect_call(1, 4'h2);
        raise(14'h0008);
        expect_none(40);
        raise(14'h0004);
        expect_call(2, 4'ha);
        raise(14'h0000);
        do_return_from_interrupt_instr();
        check("resume", 16'(in_progress), 16'h2);
        do_return_from_interrupt_instr();
        expect_call(3, 4'h2);
        drop();
        do_return_from_interrupt_instr();
        cfg('1, '0, 1'b1);
        raise(14'h0010);
        expect_call(4, 4'h1);
        do_return_from_interrupt_instr();
        expect_call(4, 4'h1);
        drop();
        do_return_from_interrupt_instr();
        wr(flic_pkg::ADDR_TIMER_CTRL_REG, 8'h01);
        repeat (8) @(posedge clk);
        raise(14'h0001);
        expect_call(0, 4'h1);
        rd(flic_pkg::ADDR_TIMER_CTRL_REG, d);
        check("edge flag", 16'(d), 16'h01);
        do_return_from_interrupt_instr();
        expect_none(40);
        wr(flic_pkg::ADDR_TIMER_CTRL_REG, 8'h00);
        expect_call(0, 4'h1);
        rd(flic_pkg::ADDR_TIMER_CTRL_REG, d);
        check("level flag", 16'(d), 16'h02);
        drop();
        do_return_from_interrupt_instr();
        wr(flic_pkg::ADDR_EXT_IRQ_CTRL_REG, 8'h45);
        repeat (8) @(posedge clk);
        raise(14'h0040);
        expect_call(6, 4'h1);
        rd(flic_pkg::ADDR_EXT_IRQ_CTRL_REG, d);
        check("edge flag 2", 16'(d), 16'h45);
        drop();
        do_return_from_interrupt_instr();
        for (int s = 0; s < 14; s++)
            round('1, 28'(xs()), 14'(1) << s);
        for (int n = 0; n < 24; n++)
            round(14'(xs()), 28'(xs()), 14'(xs()));
        print_verdict();
    end
endmodule // tb
